// ---- rtl/cwbbu_pkg.sv ----
package cwbbu_pkg;

	// Buffer geometry.
	localparam int          DEPTH   = 4;
	localparam int          PTR_W   = 2;
	localparam int          CNT_W   = 3;
	localparam logic [2:0]  CNT_MAX = 3'h4;
	localparam logic [2:0]  CNT_ONE = 3'h1;

	// Register byte addresses on the AHB-Lite port.
	localparam int          RADDR_W      = 8;
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_DIRBASE = 8'h04;
	localparam logic [7:0]  ADDR_STATUS  = 8'h08;

	// Field positions.
	localparam int CTRL_GDIS_BIT  = 0;
	localparam int ATTR_WTHR_BIT  = 3;
	localparam int ATTR_CDIS_BIT  = 4;
	localparam int ST_CNT_LSB     = 0;
	localparam int ST_MISS_LSB    = 4;
	localparam int ST_LOCK_BIT    = 8;
	localparam int ST_REORD_BIT   = 9;
	localparam int ST_HOLD_BIT    = 10;
	localparam int A20_BIT        = 20;
	localparam int PTE_W          = 12;
	localparam int HTRANS_VLD_BIT = 1;

	// Byte enable patterns.
	localparam logic [3:0]  BE_NONE = 4'h0;
	localparam logic [3:0]  BE_LO16 = 4'h3;
	localparam logic [3:0]  BE_HI16 = 4'hC;
	localparam logic [3:0]  BE_ALL  = 4'hF;
	localparam logic [3:0]  BE_UP3  = 4'hE;

	// Bus sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_DATA = 3'h2,
		ST_HOLD = 3'h4
	} cwbbu_state_e;

	// One write buffer entry.
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
		logic        io;
		logic        hit;
		logic        wthr;
		logic        cdis;
		logic        lock;
	} cwbbu_entry_s;

endpackage : cwbbu_pkg

// ---- rtl/cwbbu_top.sv ----
`timescale 1ns/10ps
// Contract
// RULE1 - Four buffer entries, one write per clock
// RULE2 - Empty buffers and idle bus: write bypasses
// RULE3 - Busy bus: buffer write, issue when free
// RULE4 - Cache hit write updates cache immediately
// RULE5 - Buffered writes leave in arrival order
// RULE6 - Read jumps writes only if hits/miss
// RULE7 - One reorder until buffers fully drain
// RULE8 - I/O read waits for all writes
// RULE9 - Single I/O write unbuffered, core stalls
// RULE10 - String output I/O writes are buffered
// RULE11 - Locked read always goes to bus
// RULE12 - Drain buffers, then lock, read, buffer
// RULE13 - Drop lock after locked write completes
// RULE14 - No foreign cycle inside locked pair
// RULE15 - Attributes from page entry or directory base
// RULE16 - Global cache disable forces cache-disable high
// RULE17 - No line fill for cache-disabled pages
// RULE18 - Attributes active high, undriven in hold
// RULE19 - Bus size sampled clock before ready
// RULE20 - Both sizes asserted means 8-bit
// RULE21 - Split wide transfers, adjust byte enables
// RULE22 - Mask address bit 20 when asked
// RULE23 - Full buffers stall further writes
module cwbbu_top
	import cwbbu_pkg::*;
(
	input  wire logic        hclk,               // System clock.
	input  wire logic        hresetn,            // Asynchronous reset, active low.
	input  wire logic        hsel,               // AHB slave select.
	input  wire logic [31:0] haddr,              // AHB address.
	input  wire logic [1:0]  htrans,             // AHB transfer type.
	input  wire logic        hwrite,             // AHB write.
	input  wire logic [2:0]  hsize,              // AHB size, words only.
	input  wire logic [31:0] hwdata,             // AHB write data.
	input  wire logic        hready,             // AHB bus ready.
	output logic      [31:0] hrdata,             // AHB read data.
	output logic             hreadyout,          // AHB slave ready.
	output logic             hresp,              // AHB response, always OKAY.
	input  wire logic        core_req_valid,     // Core request present.
	input  wire logic        core_req_write,     // Request is a write.
	input  wire logic        core_req_io,        // Request is to I/O space.
	input  wire logic        string_output_instr, // Write comes from a repeated string output.
	input  wire logic        core_req_hit,       // Request hits the on-chip cache.
	input  wire logic        core_req_locked,    // Request is part of a locked pair.
	input  wire logic        core_req_paged,     // Paging translated this request.
	input  wire logic [11:0] core_req_pte,       // Low bits of the page table entry.
	input  wire logic [31:0] core_req_addr,      // Physical address.
	input  wire logic [31:0] core_req_data,      // Write data.
	input  wire logic [3:0]  core_req_be,        // Byte enables, active high.
	output logic             core_req_ack,       // One-cycle acknowledge.
	output logic      [31:0] core_rdata,         // Read data, valid with acknowledge.
	output logic             cache_wr_strobe,    // Update cache line with the write.
	output logic      [31:0] cache_lookup_addr,  // Masked address for cache lookup.
	input  wire logic        addr20_mask_n,      // Mask address bit 20, active low.
	input  wire logic        bus_ready_n,        // Transfer ready, active low.
	input  wire logic        bus_size_16_n,      // 16-bit bus, active low.
	input  wire logic        bus_size_8_n,       // 8-bit bus, active low.
	input  wire logic [31:0] bus_rdata,          // Read data from the bus.
	input  wire logic        bus_hold,           // Hold request from another master.
	output logic             bus_hold_ack,       // Bus released.
	output logic             bus_start,          // First clock of a bus cycle.
	output logic      [31:0] bus_addr,           // Cycle address.
	output logic      [3:0]  bus_be,             // Cycle byte enables, active high.
	output logic             bus_write,          // Cycle is a write.
	output logic             bus_io,             // Cycle is to I/O space.
	output logic      [31:0] bus_wdata,          // Write data.
	output logic             bus_lock,           // Locked sequence in progress.
	output logic             page_write_through, // Page write-through attribute.
	output logic             page_cache_disable, // Page cache-disable attribute.
	output logic             attr_oe,            // Drive enable for the attributes.
	output logic             cache_fill_ok       // Cycle may become a line fill.
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		cwbbu_state_e                  state;
		cwbbu_entry_s [DEPTH-1:0]      wbuf;
		logic [PTR_W-1:0]              rd_ptr;
		logic [PTR_W-1:0]              wr_ptr;
		logic [CNT_W-1:0]              count;
		logic [CNT_W-1:0]              miss_cnt;
		logic                          reorder_used;
		logic                          lock;
		logic                          core_busy;
		logic [31:0]                   cur_addr;
		logic [31:0]                   cur_data;
		logic [3:0]                    cur_be;
		logic                          cur_write;
		logic                          cur_io;
		logic                          cur_from_buf;
		logic                          cur_ack_end;
		logic                          cur_lock_wr;
		logic                          out_wthr;
		logic                          out_cdis;
		logic                          fill_ok;
		logic                          attr_oe;
		logic                          hold_ack;
		logic                          bus_start;
		logic                          sz16;
		logic                          sz8;
		logic [31:0]                   rdata;
		logic                          core_ack;
		logic [31:0]                   core_rdata;
		logic                          cache_wr;
		logic [31:0]                   lookup_addr;
		logic                          gdis;
		logic                          dir_wthr;
		logic                          dir_cdis;
		logic                          ahb_wr;
		logic [RADDR_W-1:0]            ahb_addr;
		logic [31:0]                   hrdata;
		logic                          hready;
		logic                          hresp;
	} cwbbu_regs_s;

	cwbbu_regs_s  st;
	cwbbu_regs_s  n;
	cwbbu_entry_s head;
	logic         req_new;
	logic         bufw;
	logic         push;
	logic         pop;
	logic [31:0]  req_addr;
	logic         req_wthr;
	logic         req_cdis;
	logic [3:0]   done_be;
	logic [31:0]  rd_merge;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Clears address bit 20 while the mask input is asserted.
	function automatic logic [31:0] mask_a20(input logic [31:0] a, input logic mask_n);
		logic [31:0] r;
		r          = a;
		r[A20_BIT] = a[A20_BIT] & mask_n;
		return r;
	endfunction : mask_a20

	// Byte lanes moved by one transfer of the sampled width.
	function automatic logic [3:0] lanes_done(input logic [3:0] be, input logic w16,
		input logic w8);
		logic [3:0] r;
		r = be;
		if (w8) begin
			r = be & (4'(~be) + 4'h1);
		end else if (w16) begin
			r = ((be & BE_LO16) != BE_NONE) ? (be & BE_LO16) : (be & BE_HI16);
		end
		return r;
	endfunction : lanes_done

	assign done_be = lanes_done(st.cur_be, st.sz16, st.sz8); // RULE20 RULE21
	assign head    = st.wbuf[st.rd_ptr];

	// Only the lanes finished in this transfer take bus data.
	generate
		for (genvar g = 0; g < 4; g++) begin : g_lane
			assign rd_merge[g*8 +: 8] = done_be[g] ? bus_rdata[g*8 +: 8] : st.rdata[g*8 +: 8];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	// The acknowledge guard stops a held request from being taken twice.
	always_comb begin
		n           = st;
		push        = 1'b0;
		pop         = 1'b0;
		n.bus_start = 1'b0;
		n.core_ack  = 1'b0;
		n.cache_wr  = 1'b0;
		n.ahb_wr    = 1'b0;
		n.sz16      = ~bus_size_16_n; // RULE19
		n.sz8       = ~bus_size_8_n; // RULE19
		n.lookup_addr = mask_a20(core_req_addr, addr20_mask_n); // RULE22
		req_addr    = mask_a20(core_req_addr, addr20_mask_n); // RULE22
		req_new     = core_req_valid && !st.core_ack && !st.core_busy
			&& (!st.lock || core_req_locked); // RULE14
		bufw        = core_req_write && (!core_req_io || string_output_instr); // RULE9 RULE10
		req_wthr    = (core_req_paged && !core_req_io) ? core_req_pte[ATTR_WTHR_BIT]
			: st.dir_wthr; // RULE15
		req_cdis    = (core_req_paged && !core_req_io) ? core_req_pte[ATTR_CDIS_BIT]
			: st.dir_cdis; // RULE15

		// Register writes land in the data phase.
		if (st.ahb_wr) begin
			case (st.ahb_addr)
				ADDR_CTRL: begin
					n.gdis = hwdata[CTRL_GDIS_BIT];
				end
				ADDR_DIRBASE: begin
					n.dir_wthr = hwdata[ATTR_WTHR_BIT];
					n.dir_cdis = hwdata[ATTR_CDIS_BIT];
				end
				default: begin
				end
			endcase
		end

		// Read data is taken from the next values so a write just before is seen.
		if (hsel && hready && htrans[HTRANS_VLD_BIT]) begin
			if (hwrite) begin
				n.ahb_wr   = 1'b1;
				n.ahb_addr = haddr[RADDR_W-1:0];
			end else begin
				n.hrdata = '0;
				case (haddr[RADDR_W-1:0])
					ADDR_CTRL: begin
						n.hrdata[CTRL_GDIS_BIT] = n.gdis;
					end
					ADDR_DIRBASE: begin
						n.hrdata[ATTR_WTHR_BIT] = n.dir_wthr;
						n.hrdata[ATTR_CDIS_BIT] = n.dir_cdis;
					end
					ADDR_STATUS: begin
						n.hrdata[ST_CNT_LSB +: CNT_W]  = st.count;
						n.hrdata[ST_MISS_LSB +: CNT_W] = st.miss_cnt;
						n.hrdata[ST_LOCK_BIT]          = st.lock;
						n.hrdata[ST_REORD_BIT]         = st.reorder_used;
						n.hrdata[ST_HOLD_BIT]          = st.hold_ack;
					end
					default: begin
					end
				endcase
			end
		end

		// Bus sequencer.
		case (st.state)
			ST_IDLE: begin
				if (bus_hold && !st.lock) begin
					n.state = ST_HOLD; // RULE14
				end else if (st.count != '0) begin
					if (req_new && !core_req_write && !core_req_io && !core_req_locked
						&& !core_req_hit && st.miss_cnt == '0 && !st.reorder_used) begin
						n.reorder_used = 1'b1; // RULE6 RULE7
						n.core_busy    = 1'b1;
						n.cur_addr     = req_addr;
						n.cur_be       = core_req_be;
						n.cur_write    = 1'b0;
						n.cur_io       = 1'b0;
						n.cur_from_buf = 1'b0;
						n.cur_ack_end  = 1'b1;
						n.cur_lock_wr  = 1'b0;
						n.out_wthr     = req_wthr;
						n.out_cdis     = req_cdis | st.gdis; // RULE16
						n.fill_ok      = !(req_cdis | st.gdis); // RULE17
					end else begin
						n.cur_addr     = head.addr; // RULE3 RULE5
						n.cur_data     = head.data;
						n.cur_be       = head.be;
						n.cur_write    = 1'b1;
						n.cur_io       = head.io;
						n.cur_from_buf = 1'b1;
						n.cur_ack_end  = 1'b0;
						n.cur_lock_wr  = head.lock;
						n.out_wthr     = head.wthr;
						n.out_cdis     = head.cdis | st.gdis; // RULE16
						n.fill_ok      = 1'b0;
					end
					n.bus_start = 1'b1;
					n.rdata     = '0;
					n.state     = ST_DATA;
				end else if (req_new) begin
					// Bypass writes, reads, locked reads and single I/O writes.
					n.cur_addr     = req_addr; // RULE2 RULE8 RULE11
					n.cur_data     = core_req_data;
					n.cur_be       = core_req_be;
					n.cur_write    = core_req_write;
					n.cur_io       = core_req_io;
					n.cur_from_buf = 1'b0;
					n.cur_ack_end  = !bufw; // RULE9
					n.cur_lock_wr  = core_req_locked && core_req_write;
					n.out_wthr     = req_wthr;
					n.out_cdis     = req_cdis | st.gdis; // RULE16
					n.fill_ok      = !core_req_write && !core_req_io && !core_req_locked
						&& !(req_cdis | st.gdis); // RULE17
					n.bus_start    = 1'b1;
					n.rdata        = '0;
					n.state        = ST_DATA;
					if (core_req_locked && !core_req_write) begin
						n.lock = 1'b1; // RULE12
					end
					if (bufw) begin
						n.core_ack = 1'b1; // RULE2
						n.cache_wr = core_req_hit; // RULE4
					end else begin
						n.core_busy = 1'b1; // RULE9
					end
				end
			end
			ST_DATA: begin
				if (!st.bus_start && !bus_ready_n) begin
					n.rdata = rd_merge;
					if ((st.cur_be & ~done_be) != BE_NONE) begin
						n.cur_be    = st.cur_be & ~done_be; // RULE21
						n.bus_start = 1'b1;
					end else begin
						n.state = ST_IDLE;
						if (st.cur_from_buf) begin
							pop      = 1'b1; // RULE23
							n.rd_ptr = st.rd_ptr + PTR_W'(1);
						end
						if (st.cur_lock_wr) begin
							n.lock = 1'b0; // RULE13
						end
						if (st.cur_ack_end) begin
							n.core_ack   = 1'b1; // RULE9
							n.core_busy  = 1'b0;
							n.core_rdata = rd_merge;
						end
					end
				end
			end
			ST_HOLD: begin
				if (!bus_hold) begin
					n.state = ST_IDLE;
				end
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase

		// Writes not bypassed enter the buffer while an entry is free.
		if (req_new && bufw && !n.core_ack && st.count < CNT_MAX) begin
			push                = 1'b1; // RULE1 RULE23
			n.wbuf[st.wr_ptr]   = '{addr: req_addr, data: core_req_data, be: core_req_be,
				io: core_req_io, hit: core_req_hit, wthr: req_wthr, cdis: req_cdis,
				lock: core_req_locked};
			n.wr_ptr            = st.wr_ptr + PTR_W'(1);
			n.core_ack          = 1'b1;
			n.cache_wr          = core_req_hit; // RULE4
		end

		n.count    = st.count + CNT_W'(push) - CNT_W'(pop);
		n.miss_cnt = st.miss_cnt + CNT_W'(push && !core_req_hit)
			- CNT_W'(pop && !head.hit);
		if (n.count == '0) begin
			n.reorder_used = 1'b0; // RULE7
		end
		n.hold_ack = (n.state == ST_HOLD);
		n.attr_oe  = (n.state != ST_HOLD); // RULE18
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	// Reset leaves the buffers empty and the bus idle with attributes driven.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st         <= '0;
			st.state   <= ST_IDLE;
			st.attr_oe <= 1'b1;
			st.hready  <= 1'b1;
		end else begin
			st <= n;
		end
	end

	// Outputs straight from state.
	assign hrdata             = st.hrdata;
	assign hreadyout          = st.hready;
	assign hresp              = st.hresp;
	assign core_req_ack       = st.core_ack;
	assign core_rdata         = st.core_rdata;
	assign cache_wr_strobe    = st.cache_wr;
	assign cache_lookup_addr  = st.lookup_addr;
	assign bus_hold_ack       = st.hold_ack;
	assign bus_start          = st.bus_start;
	assign bus_addr           = st.cur_addr;
	assign bus_be             = st.cur_be;
	assign bus_write          = st.cur_write;
	assign bus_io             = st.cur_io;
	assign bus_wdata          = st.cur_data;
	assign bus_lock           = st.lock;
	assign page_write_through = st.out_wthr;
	assign page_cache_disable = st.out_cdis;
	assign attr_oe            = st.attr_oe;
	assign cache_fill_ok      = st.fill_ok;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_last_ready;
		st.state == ST_DATA && !st.bus_start && !bus_ready_n;
	endsequence

	sequence s_full_byte8;
		s_last_ready ##0 st.sz8 && st.cur_be == BE_ALL;
	endsequence

	AST_DEPTH: assert property (st.count <= CNT_MAX) // RULE1
		else $error("buffer count above depth");
	AST_BYPASS: assert property ((req_new && bufw && st.count == '0 && st.state == ST_IDLE
		&& !bus_hold) |=> st.bus_start && st.cur_write && !st.cur_from_buf
		&& st.count == '0) // RULE2
		else $error("write on idle bus was not bypassed");
	AST_FULL: assert property ((st.count == CNT_MAX && !pop) |=> st.count == CNT_MAX) // RULE23
		else $error("full buffer accepted a write");
	AST_IO_READ: assert property ((st.bus_start && st.cur_io && !st.cur_write)
		|-> st.count == '0) // RULE8
		else $error("io read passed buffered writes");
	AST_LOCK_EMPTY: assert property ($rose(st.lock) |-> st.count == '0 && st.bus_start
		&& !st.cur_write) // RULE12
		else $error("lock asserted with writes pending");
	AST_LOCK_DROP: assert property ($fell(st.lock) |-> $past(st.cur_lock_wr, 1)) // RULE13
		else $error("lock dropped before locked write");
	AST_NO_HOLD_LOCK: assert property (st.lock |-> st.state != ST_HOLD) // RULE14
		else $error("bus released inside locked sequence");
	AST_CDIS_FORCE: assert property ((st.bus_start && $past(st.gdis)) |-> st.out_cdis) // RULE16
		else $error("cache disable not forced");
	AST_NO_FILL: assert property ((st.bus_start && st.out_cdis) |-> !st.fill_ok) // RULE17
		else $error("fill allowed on uncached page");
	AST_HOLD_FLOAT: assert property ((st.state == ST_IDLE && bus_hold && !st.lock)
		|=> !st.attr_oe && st.hold_ack) // RULE18
		else $error("attributes driven during hold");
	AST_SPLIT8: assert property (s_full_byte8 |=> st.bus_start && st.cur_be == BE_UP3) // RULE21
		else $error("8-bit split wrong");
	AST_BOTH_SIZE: assert property ((s_last_ready ##0 st.sz8 && st.sz16
		&& st.cur_be == BE_ALL) |=> st.cur_be == BE_UP3) // RULE20
		else $error("both sizes not treated as 8-bit");
	AST_A20: assert property (!addr20_mask_n |=> !st.lookup_addr[A20_BIT]) // RULE22
		else $error("address bit 20 not masked");

endmodule : cwbbu_top

// ---- verif/cwbbu_bus_model.sv ----
`timescale 1ns/10ps
// Far-side bus logic: answers each transfer after a set number of wait states and logs it.
module cwbbu_bus_model (
	input  wire logic        hclk,               // Clock.
	input  wire logic        hresetn,            // Reset, active low.
	input  wire logic        bus_start,          // First clock of a transfer.
	input  wire logic [31:0] bus_addr,           // Transfer address.
	input  wire logic [3:0]  bus_be,             // Byte enables.
	input  wire logic        bus_write,          // Write transfer.
	input  wire logic        bus_lock,           // Locked sequence.
	input  wire logic        page_write_through, // Attribute.
	input  wire logic        page_cache_disable, // Attribute.
	input  wire logic        cache_fill_ok,      // Fill allowed.
	input  wire logic [3:0]  wait_cycles,        // Wait states per transfer.
	input  wire logic [1:0]  size_sel,           // Bit 0 asks 16-bit, bit 1 asks 8-bit.
	output logic             bus_ready_n,        // Ready, active low.
	output logic             bus_size_16_n,      // 16-bit size, active low.
	output logic             bus_size_8_n,       // 8-bit size, active low.
	output logic      [31:0] bus_rdata           // Read data.
);
	logic        busy;
	logic [3:0]  wq;
	int          n;
	logic [31:0] la [256];
	logic [3:0]  lbe [256];
	logic [4:0]  lf [256];
	////////////////////////////////////////////////////////////////
	// Sizes stand still, so the sample in the clock before ready is always the intended one.
	assign bus_size_16_n = !size_sel[0];
	assign bus_size_8_n  = !size_sel[1];
	// Outside the ready clock the data lines show another pattern, never the answer.
	assign bus_rdata = bus_addr ^ (bus_ready_n ? 32'hA5A5A5A5 : 32'h5A5A5A5A);
	// One transfer at a time; this side never starts a cycle inside a locked pair.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			wq <= 4'h0;
			bus_ready_n <= 1'b1;
			n <= 0;
		end else if (bus_start) begin
			busy <= 1'b1;
			wq <= wait_cycles;
			bus_ready_n <= (wait_cycles != 4'h0);
		end else if (busy && !bus_ready_n) begin
			busy <= 1'b0;
			bus_ready_n <= 1'b1;
			la[n] <= bus_addr;
			lbe[n] <= bus_be;
			lf[n] <= {cache_fill_ok, page_cache_disable, page_write_through, bus_lock, bus_write};
			n <= n + 1;
		end else if (busy) begin
			wq <= wq - 4'h1;
			bus_ready_n <= (wq > 4'h1);
		end
	end
endmodule : cwbbu_bus_model

// ---- verif/cwbbu_top_bench.sv ----
`timescale 1ns/10ps
module cwbbu_top_bench
	import cwbbu_pkg::*;
;
	localparam logic [5:0] W = 6'h20, IO = 6'h10, SO = 6'h08, HIT = 6'h04, LK = 6'h02, PG = 6'h01;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, bus_hold = 1'b0;
	logic        core_req_valid = 1'b0, core_req_write = 1'b0, core_req_io = 1'b0;
	logic        string_output_instr = 1'b0, core_req_hit = 1'b0, core_req_locked = 1'b0;
	logic        core_req_paged = 1'b0, addr20_mask_n = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, core_req_addr = 32'h0, rd, r;
	logic [1:0]  htrans = 2'h0, size_sel = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [3:0]  wait_cycles = 4'h0, core_req_be = 4'hF;
	logic [11:0] core_req_pte = 12'h0;
	wire  logic [31:0] core_req_data = ~core_req_addr;
	wire  logic [31:0] hrdata, core_rdata, bus_rdata, bus_addr, bus_wdata, cache_lookup_addr;
	wire  logic [3:0]  bus_be;
	wire  logic        hreadyout, hresp, core_req_ack, cache_wr_strobe, bus_ready_n, bus_size_16_n;
	wire  logic        bus_size_8_n, bus_hold_ack, bus_start, bus_write, bus_io, bus_lock, hready;
	wire  logic        page_write_through, page_cache_disable, attr_oe, cache_fill_ok;
	int          fail_count = 0, check_count = 0, lat, cyc = 0;
	assign hready = hreadyout;
	cwbbu_top dut_u (.*);
	cwbbu_bus_model m_u (.*);
	always #25 hclk = ~hclk;
	// Cut a hang short; all scenarios together need a few hundred clocks.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			results;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	// Single word transfer; each phase stands until ready is sampled high.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : ahb
	// Valid stays up after the ack so the next request can follow at once.
	task automatic cop(input logic [5:0] f, input logic [31:0] a);
		{core_req_write, core_req_io, string_output_instr, core_req_hit, core_req_locked,
			core_req_paged} <= f;
		core_req_addr <= a;
		core_req_valid <= 1'b1;
		lat = 0;
		do begin
			@(posedge hclk);
			lat++;
		end while (core_req_ack !== 1'b1 && lat < 400);
		if (core_req_ack !== 1'b1) fail_count++;
		rd = core_rdata;
	endtask : cop
	// Quiet means nothing in flight and no transfer started for four clocks.
	task automatic drain;
		int q;
		q = 0;
		core_req_valid <= 1'b0;
		for (int i = 0; i < 400 && q < 4; i++) begin
			@(posedge hclk);
			q = (m_u.busy || bus_start) ? 0 : q + 1;
		end
		if (q < 4) fail_count++;
	endtask : drain
	task automatic t_wbuf;
		int b;
		b = m_u.n;
		wait_cycles <= 4'h8;
		for (int i = 0; i < 6; i++) begin
			cop(W | HIT, 32'h100 + 4 * i);
			if (i == 0) chk("bypass start", 1, bus_start);
			chk("cache strobe", 1, cache_wr_strobe);
			if (i > 0 && i < 5) chk("buffered ack", 2, lat);
			if (i == 5) chk("full stall", 1, lat > 2);
		end
		drain;
		for (int i = 0; i < 6; i++) chk("write order", 32'h100 + 4 * i, m_u.la[b + i]);
		$display("test write buffers done");
	endtask : t_wbuf
	task automatic t_size;
		logic [15:0] ex [3] = '{16'hFEC8, 16'hFEC8, 16'hFC00};
		logic [1:0]  sel [3] = '{2'h2, 2'h3, 2'h1};
		int          b, k;
		for (int j = 0; j < 3; j++) begin
			b = m_u.n;
			size_sel <= sel[j];
			wait_cycles <= 4'h0;
			cop(W, 32'h200);
			drain;
			k = (j == 2) ? 2 : 4;
			chk("pieces", k, m_u.n - b);
			for (int i = 0; i < k; i++) chk("piece be", ex[j][15 - 4 * i -: 4], m_u.lbe[b + i]);
		end
		size_sel <= 2'h0;
		$display("test bus size done");
	endtask : t_size
	task automatic t_io;
		int b;
		b = m_u.n;
		wait_cycles <= 4'h5;
		cop(W | IO, 32'h300);
		chk("io write on bus", b + 1, m_u.n);
		chk("io cycle", 1, bus_io);
		cop(W | HIT, 32'h304);
		cop(W | IO | SO, 32'h308);
		chk("string write buffered", 2, lat);
		cop(IO, 32'h30C);
		chk("io read after writes", b + 4, m_u.n);
		chk("io read last", 32'h30C, m_u.la[b + 3]);
		drain;
		$display("test io done");
	endtask : t_io
	task automatic t_reorder;
		logic [11:0] ord [8] = '{12'h400, 12'h40C, 12'h404, 12'h408, 12'h410, 12'h414, 12'h418,
			12'h41C};
		int          b;
		b = m_u.n;
		wait_cycles <= 4'h6;
		cop(W | HIT, 32'h400);
		cop(W | HIT, 32'h404);
		cop(W | HIT, 32'h408);
		cop(6'h00, 32'h40C);
		chk("read data", 32'h40C ^ 32'h5A5A5A5A, rd);
		cop(6'h00, 32'h410);
		cop(W, 32'h414);
		cop(W, 32'h418);
		cop(6'h00, 32'h41C);
		drain;
		for (int i = 0; i < 8; i++) chk("bus order", 32'(ord[i]), m_u.la[b + i]);
		$display("test reorder done");
	endtask : t_reorder
	task automatic t_lock;
		int b;
		b = m_u.n;
		wait_cycles <= 4'h3;
		cop(W, 32'h500);
		cop(W, 32'h504);
		cop(LK | HIT, 32'h508);
		chk("locked read on bus", 32'h508, m_u.la[m_u.n - 1]);
		chk("drained unlocked", 0, m_u.lf[b + 1][1]);
		chk("read locked", 1, m_u.lf[b + 2][1]);
		bus_hold <= 1'b1;
		cop(W | LK, 32'h508);
		chk("no hold inside pair", 0, bus_hold_ack);
		drain;
		chk("write next", 32'h508, m_u.la[b + 3]);
		chk("write locked", 1, m_u.lf[b + 3][1]);
		chk("lock dropped", 0, bus_lock);
		chk("hold granted", 1, bus_hold_ack);
		chk("attributes undriven", 0, attr_oe);
		bus_hold <= 1'b0;
		repeat (2) @(posedge hclk);
		$display("test lock done");
	endtask : t_lock
	task automatic t_attr;
		logic [5:0]  fs [5] = '{W | PG, W | IO, W | PG, PG, PG};
		logic [11:0] ps [5] = '{12'h008, 12'h000, 12'h000, 12'h010, 12'h000};
		logic [4:0]  ex [5] = '{5'h05, 5'h0D, 5'h09, 5'h08, 5'h10};
		int          b;
		ahb(1'b1, ADDR_DIRBASE, 32'h18);
		ahb(1'b0, ADDR_DIRBASE, 32'h0);
		chk("dirbase", 32'h18, r);
		b = m_u.n;
		wait_cycles <= 4'h0;
		for (int i = 0; i < 5; i++) begin
			ahb(1'b1, ADDR_CTRL, 32'(i == 2) << CTRL_GDIS_BIT);
			core_req_pte <= ps[i];
			cop(fs[i], 32'h600 + 4 * i);
			drain;
			chk("attributes", 32'(ex[i]), 32'(m_u.lf[b + i]));
		end
		addr20_mask_n <= 1'b0;
		cop(W, 32'h00100700);
		drain;
		chk("a20 masked", 32'h00000700, m_u.la[b + 5]);
		chk("lookup masked", 32'h00000700, cache_lookup_addr);
		chk("write data", 32'hFFEFF8FF, bus_wdata);
		addr20_mask_n <= 1'b1;
		$display("test attributes done");
	endtask : t_attr
	// Main sequence; the mask input stays high across the reset release.
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("attr driven", 1, attr_oe);
		chk("okay", 0, hresp);
		ahb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 0, r);
		t_wbuf;
		t_size;
		t_io;
		t_reorder;
		t_lock;
		t_attr;
		results;
	end
endmodule : cwbbu_top_bench
